// ### bench/d2ci_cmd_if_tb.sv
`timescale 1ns/100ps
module d2ci_cmd_if_tb
  import d2ci_pkg::*;
;
  typedef struct {
    logic       pg;
    logic [2:0] cl;
    logic [2:0] al;
    logic       bl8;
    logic       il;
    logic [7:0] ws;
    logic [7:0] rs;
    logic       ap;
    int         rl;
  } d2ci_row_t;

  logic                  clk_sys;
  logic                  rstn;
  logic                  termination_control;
  d2ci_cmd_t             cmd;
  d2ci_wbeat_t           wr_beat;
  d2ci_rbeat_t           rd_beat;
  logic                  rd_valid, dq_oe, termination_on, drive_reduced, dll_locked, cmd_refused;
  d2ci_pwr_t             power_state;
  logic [D2CI_NBANK-1:0] bank_open;
  logic [31:0]           exp_mem [256];
  logic                  s0, s1, s2;
  int                    fails, check_count;
  d2ci_row_t             r;
  // last row asks for an illegal latency, the previous one must survive
  d2ci_row_t rows [5] = '{
    '{1'b0, 3'h3, 3'h0, 1'b0, 1'b0, 8'h01, 8'h00, 1'b0, 3},
    '{1'b1, 3'h4, 3'h1, 1'b1, 1'b1, 8'h05, 8'h02, 1'b0, 5},
    '{1'b1, 3'h5, 3'h5, 1'b0, 1'b1, 8'h02, 8'h01, 1'b1, 10},
    '{1'b1, 3'h6, 3'h2, 1'b1, 1'b0, 8'h03, 8'h06, 1'b1, 8},
    '{1'b1, 3'h7, 3'h0, 1'b1, 1'b0, 8'h00, 8'h03, 1'b0, 6}};
  logic [16:0] mrs [5] = '{
    {2'h1, 13'h0002, 2'b10}, {2'h2, 13'h0000, 2'b10}, {2'h0, 13'h0062, 2'b10},
    {2'h1, 13'h0000, 2'b00}, {2'h1, 13'h0804, 2'b01}};

  d2ci_cmd_if #(.DLL_LOCK_CYC(4)) dut_u (.clk_sys(clk_sys), .rstn(rstn), .cmd(cmd),
    .termination_control(termination_control), .wr_beat(wr_beat), .rd_beat(rd_beat),
    .rd_valid(rd_valid), .dq_oe(dq_oe), .termination_on(termination_on), .drive_reduced(drive_reduced),
    .dll_locked(dll_locked), .power_state(power_state), .bank_open(bank_open), .cmd_refused(cmd_refused));
  d2ci_ctrl_model ctrl_u (.clk_sys(clk_sys), .cmd(cmd), .wr_beat(wr_beat));

  // ****************************************
  // helpers
  // ****************************************
  task automatic chk(input string nm, input logic [63:0] exp, input logic [63:0] got);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask

  function automatic logic [7:0] colk(input logic [7:0] s, input int k, input logic bl8, input logic il);
    logic [7:0] mk;
    mk = bl8 ? 8'h07 : 8'h03;
    colk = il ? (s ^ k[7:0]) : ((s & ~mk) | ((s + k[7:0]) & mk));
  endfunction

  task automatic wr_row(input int i, input d2ci_row_t r, input logic [3:0] mk, input logic men);
    logic [31:0] w [16];
    logic [3:0]  m [16];
    logic [7:0]  c;
    int          nb;
    nb = r.bl8 ? 4 : 2;
    for (int k = 0; k < 2 * nb; k++) begin
      w[k] = {8'ha5, i[7:0], 8'h3c, k[7:0]};
      m[k] = k[0] ? mk : 4'h0;
      c = colk(r.ws, k, r.bl8, r.il);
      for (int l = 0; l < 4; l++)
        if (!(men && m[k][l])) exp_mem[c][8*l +: 8] = w[k][8*l +: 8];
    end
    ctrl_u.wr(2'h1, {5'h0, r.ws}, r.rl, nb, w, m);
  endtask

  task automatic rd_chk(input d2ci_row_t r);
    int         j;
    int         nb;
    logic [3:0] eb;
    nb = r.bl8 ? 4 : 2;
    eb = 4'h0;
    eb[1] = ~r.ap;
    ctrl_u.send(1'b1, 1'b0, 3'h5, 2'h1, {2'h0, r.ap, 2'h0, r.rs});
    for (int e = 1; e <= r.rl + nb; e++) begin
      tick(1);
      j = 2 * (e - r.rl);
      chk("rd_valid", {2{e >= r.rl && e < r.rl + nb}}, {rd_valid, dq_oe});
      if (j >= 0 && j < 2 * nb)
        chk("rd_beat", {exp_mem[colk(r.rs, j, r.bl8, r.il)], exp_mem[colk(r.rs, j + 1, r.bl8, r.il)]},
            rd_beat);
    end
    chk("bank_open", eb, bank_open);
  endtask

  task automatic finish_test;
    if (fails == 0 && check_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // ****************************************
  // clock, reset, watchdog
  // ****************************************
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  initial begin
    repeat (5000) @(posedge clk_sys);
    fails++;
    finish_test();
  end

  // ****************************************
  // tests
  // ****************************************
  initial begin
    fails = 0;
    check_count = 0;
    rstn = 1'b0;
    termination_control = 1'b0;
    repeat (10) @(posedge clk_sys);
    rstn <= 1'b1;
    ctrl_u.send(1'b1, 1'b0, 3'h7, 2'h0, 13'h0);
    tick(1);
    chk("reset_out", {PWR_ON, 4'h0, 4'h0}, {power_state, bank_open, rd_valid, drive_reduced,
        termination_on, dll_locked});
    tick(6);
    chk("dll_locked", 1'b1, dll_locked);
    foreach (rows[i]) begin
      r = rows[i];
      if (r.pg) begin
        ctrl_u.send(1'b1, 1'b0, 3'h0, 2'h0, {6'h0, r.cl, r.il, r.bl8 ? D2CI_BL8_CODE : D2CI_BL4_CODE});
        ctrl_u.send(1'b1, 1'b0, 3'h0, 2'h1, {7'h0, r.al, 3'h0});
      end
      ctrl_u.send(1'b1, 1'b0, 3'h2, 2'h0, 13'h0400);
      ctrl_u.act(2'h1, 13'h0005);
      wr_row(i, r, 4'h5, 1'b0);
      rd_chk(r);
    end
    ctrl_u.send(1'b1, 1'b1, 3'h3, 2'h2, 13'h0001);
    tick(2);
    chk("bank_open", 4'h2, bank_open);
    ctrl_u.send(1'b1, 1'b1, 3'h5, 2'h1, 13'h0000);
    for (int e = 0; e < 8; e++) begin
      tick(1);
      chk("cs_read", 2'h0, {rd_valid, cmd_refused});
    end
    ctrl_u.send(1'b1, 1'b0, 3'h5, 2'h2, 13'h0000);
    #1 s0 = cmd_refused;
    tick(1);
    s1 = cmd_refused;
    tick(1);
    s2 = cmd_refused;
    chk("cmd_refused", 2'd1, s0 + s1 + s2);
    ctrl_u.act(2'h0, 13'h0002);
    ctrl_u.send(1'b1, 1'b0, 3'h2, 2'h0, 13'h0000);
    tick(2);
    chk("pre_one", 4'h2, bank_open);
    ctrl_u.send(1'b1, 1'b0, 3'h2, 2'h3, 13'h0400);
    tick(2);
    chk("pre_all", 4'h0, bank_open);
    termination_control <= 1'b1;
    foreach (mrs[i]) begin
      ctrl_u.send(1'b1, 1'b0, 3'h0, mrs[i][16:15], mrs[i][14:2]);
      tick(2);
      chk("drive_term", mrs[i][1:0], {drive_reduced, termination_on});
    end
    r = '{1'b0, 3'h6, 3'h0, 1'b0, 1'b0, 8'h04, 8'h05, 1'b0, 6};
    ctrl_u.act(2'h1, 13'h0005);
    wr_row(9, r, 4'h5, 1'b1);
    rd_chk(r);
    ctrl_u.send(1'b1, 1'b0, 3'h5, 2'h1, 13'h0000);
    ctrl_u.send(1'b1, 1'b0, 3'h5, 2'h1, 13'h0000);
    #1 s0 = cmd_refused;
    tick(10);
    chk("busy_refused", 2'h2, {s0, cmd_refused});
    ctrl_u.send(1'b0, 1'b0, 3'h7, 2'h0, 13'h0);
    tick(1);
    chk("act_pd", PWR_ACT_PD, power_state);
    ctrl_u.send(1'b0, 1'b0, 3'h2, 2'h1, 13'h0400);
    tick(1);
    chk("pd_ignore", 4'h2, bank_open);
    ctrl_u.send(1'b1, 1'b0, 3'h7, 2'h0, 13'h0);
    tick(1);
    chk("pd_exit", PWR_ON, power_state);
    ctrl_u.send(1'b1, 1'b0, 3'h2, 2'h1, 13'h0400);
    ctrl_u.send(1'b0, 1'b0, 3'h7, 2'h0, 13'h0);
    tick(1);
    chk("pre_pd", {PWR_PRE_PD, 4'h0}, {power_state, bank_open});
    ctrl_u.send(1'b1, 1'b0, 3'h7, 2'h0, 13'h0);
    ctrl_u.send(1'b0, 1'b0, 3'h1, 2'h0, 13'h0);
    tick(1);
    chk("self_ref", {PWR_SELF, 1'b0}, {power_state, termination_on});
    ctrl_u.send(1'b1, 1'b0, 3'h7, 2'h0, 13'h0);
    tick(1);
    chk("sr_exit", PWR_ON, power_state);
    rstn <= 1'b0;
    tick(2);
    chk("mid_reset", {PWR_ON, 2'h0}, {power_state, dll_locked, termination_on});
    finish_test();
  end
endmodule

// ### bench/d2ci_ctrl_model.sv
`timescale 1ns/100ps
module d2ci_ctrl_model
  import d2ci_pkg::*;
(
  input  wire logic clk_sys,
  output d2ci_cmd_t   cmd,
  output d2ci_wbeat_t wr_beat
);
  // ****************************************
  // idle state
  // ****************************************
  initial begin
    cmd     = {1'b0, 1'b1, 3'h7, 2'h0, 13'h0};
    wr_beat = '0;
  end

  // ****************************************
  // command and write issue
  // ****************************************
  // cke stays at the issued level, so a burst is never cut by a drop
  task automatic send(input logic ck, input logic cs, input logic [2:0] rcw, input logic [1:0] b,
                      input logic [12:0] a);
    @(posedge clk_sys);
    cmd <= {ck, cs, rcw, b, a};
    @(posedge clk_sys);
    cmd <= {ck, 1'b0, 3'h7, ~b, ~a};
  endtask

  // row timing rounded up at 10 ns: three idle edges before the column command
  task automatic act(input logic [1:0] b, input logic [12:0] row);
    send(1'b1, 1'b0, 3'h3, b, row);
    repeat (2) @(posedge clk_sys);
  endtask

  // idle data toggles every cycle so a stale word never looks valid
  task automatic wr(input logic [1:0] b, input logic [12:0] a, input int rl, input int nb,
                    input logic [31:0] w [16], input logic [3:0] m [16]);
    int j;
    send(1'b1, 1'b0, 3'h4, b, a);
    for (int e = 0; e < rl + nb; e++) begin
      if (e > 0) @(posedge clk_sys);
      j = 2 * (e - rl + 1);
      if (e >= rl - 1 && e < rl - 1 + nb) wr_beat <= {w[j], w[j+1], m[j], m[j+1]};
      else wr_beat <= ~wr_beat;
    end
  endtask
endmodule

// ### logic/d2ci_cmd_if.sv
`timescale 1ns/100ps
module d2ci_cmd_if
  import d2ci_pkg::*;
#(
  parameter int DLL_LOCK_CYC = D2CI_DLL_LOCK_CYC
) (
  input  wire  logic            clk_sys,
  input  wire  logic            rstn,
  input  wire  d2ci_cmd_t       cmd,
  input  wire  logic            termination_control,
  input  wire  d2ci_wbeat_t     wr_beat,
  output d2ci_rbeat_t           rd_beat,
  output logic                  rd_valid,
  output logic                  dq_oe,
  output logic                  termination_on,
  output logic                  drive_reduced,
  output logic                  dll_locked,
  output d2ci_pwr_t             power_state,
  output logic [D2CI_NBANK-1:0] bank_open,
  output logic                  cmd_refused
);

  localparam int MEM_AW = D2CI_BA_W + D2CI_ROW_KEEP + D2CI_COL_W;

  // ****************************************
  // command decode
  // ****************************************
  d2ci_op_t                   op;
  logic                       rx_on;
  logic                       acc_ok;
  logic                       rd_go;
  logic                       wr_go;
  logic                       cke_q;

  always_comb begin
    if (cmd.cs_n) begin
      op = OP_DESEL;
    end else begin
      case ({cmd.ras_n, cmd.cas_n, cmd.we_n})
        3'h7:    op = OP_NOP;
        3'h3:    op = OP_ACT;
        3'h5:    op = OP_READ;
        3'h4:    op = OP_WRITE;
        3'h2:    op = OP_PRE;
        3'h1:    op = OP_REF;
        3'h0:    op = OP_MRS;
        default: op = OP_NOP;
      endcase
    end
  end

  // all sampling is on the rising edge, standing for the CK/CK# crossing
  assign rx_on = (power_state == PWR_ON) && cmd.cke;

  // ****************************************
  // configuration
  // ****************************************
  logic [2:0]                 read_latency;
  logic [2:0]                 posted_latency;
  logic                       burst8;
  logic                       interleave;
  logic                       mask_en;
  logic                       odt_en;
  logic                       dll_en;
  logic                       dll_rst;
  logic [3:0]                 rl_total;
  logic [2:0]                 next_cl;
  logic [2:0]                 next_al;
  logic [2:0]                 next_bl;

  assign next_cl  = cmd.addr[D2CI_MR_CL_LSB +: 3];
  assign next_al  = cmd.addr[D2CI_E1_AL_LSB +: 3];
  assign next_bl  = cmd.addr[D2CI_MR_BL_LSB +: 3];
  assign rl_total = 4'(read_latency) + 4'(posted_latency);
  assign dll_rst  = rx_on && (op == OP_MRS) && (cmd.ba == 2'h0) && cmd.addr[D2CI_MR_DRST_BIT];

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      read_latency   <= D2CI_RST_CL;
      posted_latency <= D2CI_RST_AL;
      burst8         <= 1'b0;
      interleave     <= 1'b0;
      mask_en        <= 1'b0;
      odt_en         <= 1'b0;
      dll_en         <= 1'b1;
      drive_reduced  <= 1'b0;
    end else if (rx_on && (op == OP_MRS)) begin
      case (cmd.ba)
        2'h0: begin
          // illegal codes keep the old setting rather than corrupt timing
          if (next_cl >= D2CI_CL_MIN && next_cl <= D2CI_CL_MAX) begin
            read_latency <= next_cl;
          end
          if (next_bl == D2CI_BL4_CODE || next_bl == D2CI_BL8_CODE) begin
            burst8 <= (next_bl == D2CI_BL8_CODE);
          end
          interleave <= cmd.addr[D2CI_MR_BT_BIT];
        end
        2'h1: begin
          if (next_al <= D2CI_AL_MAX) begin
            posted_latency <= next_al;
          end
          dll_en        <= !cmd.addr[D2CI_E1_DDIS_BIT];
          drive_reduced <= cmd.addr[D2CI_E1_DRV_BIT];
          odt_en        <= cmd.addr[D2CI_E1_ODT0_BIT] || cmd.addr[D2CI_E1_ODT1_BIT];
          mask_en       <= cmd.addr[D2CI_E1_MSK_BIT];
        end
        default: begin
          // higher extended registers carry nothing this block acts on
        end
      endcase
    end
  end

  // ****************************************
  // delay-locked loop
  // ****************************************
  logic [15:0]                dll_cnt;

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      dll_cnt    <= 16'h0000;
      dll_locked <= 1'b0;
    end else if (!dll_en || dll_rst) begin
      dll_cnt    <= 16'h0000;
      dll_locked <= 1'b0;
    end else if (dll_cnt == 16'(DLL_LOCK_CYC - 1)) begin
      dll_locked <= 1'b1;
    end else begin
      dll_cnt <= dll_cnt + 16'h0001;
    end
  end

  // ****************************************
  // banks
  // ****************************************
  logic [D2CI_ROW_W-1:0]      open_row [D2CI_NBANK];
  d2ci_eng_t                  eng;
  logic [3:0]                 eng_cnt;
  logic [1:0]                 eng_beat;
  logic                       eng_wr;
  logic [D2CI_BA_W-1:0]       eng_ba;
  logic [D2CI_ROW_KEEP-1:0]   eng_row;
  logic [D2CI_COL_W-1:0]      eng_col;
  logic                       eng_ap;
  logic                       last_beat;

  assign last_beat = (eng == ENG_XFER) && (eng_beat == (burst8 ? 2'h3 : 2'h1));

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      bank_open <= '0;
      for (int i = 0; i < D2CI_NBANK; i++) begin
        open_row[i] <= '0;
      end
    end else begin
      if (last_beat && eng_ap) begin
        bank_open[eng_ba] <= 1'b0;
      end
      if (rx_on && op == OP_ACT) begin
        bank_open[cmd.ba] <= 1'b1;
        open_row[cmd.ba]  <= cmd.addr;
      end else if (rx_on && op == OP_PRE) begin
        if (cmd.addr[D2CI_AP_BIT]) begin
          bank_open <= '0;
        end else begin
          bank_open[cmd.ba] <= 1'b0;
        end
      end
    end
  end

  // ****************************************
  // burst engine
  // ****************************************
  // one access in flight; a column command during a burst is refused
  assign acc_ok = rx_on && (eng == ENG_IDLE) && bank_open[cmd.ba];
  assign rd_go  = acc_ok && (op == OP_READ);
  assign wr_go  = acc_ok && (op == OP_WRITE);

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      eng      <= ENG_IDLE;
      eng_cnt  <= 4'h0;
      eng_beat <= 2'h0;
      eng_wr   <= 1'b0;
      eng_ba   <= '0;
      eng_row  <= '0;
      eng_col  <= '0;
      eng_ap   <= 1'b0;
    end else begin
      case (eng)
        ENG_IDLE: begin
          if (rd_go || wr_go) begin
            eng      <= ENG_WAIT;
            // same count for both: write data lands one cycle earlier
            eng_cnt  <= rl_total - 4'h1;
            eng_beat <= 2'h0;
            eng_wr   <= wr_go;
            eng_ba   <= cmd.ba;
            eng_row  <= open_row[cmd.ba][D2CI_ROW_KEEP-1:0];
            eng_col  <= cmd.addr[D2CI_COL_W-1:0];
            eng_ap   <= cmd.addr[D2CI_AP_BIT];
          end
        end
        ENG_WAIT: begin
          if (eng_cnt == 4'h1) begin
            eng <= ENG_XFER;
          end else begin
            eng_cnt <= eng_cnt - 4'h1;
          end
        end
        ENG_XFER: begin
          eng_beat <= eng_beat + 2'h1;
          if (last_beat) begin
            eng <= ENG_IDLE;
          end
        end
        default: eng <= ENG_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      cmd_refused <= 1'b0;
    end else begin
      cmd_refused <= rx_on && (op == OP_READ || op == OP_WRITE) && !acc_ok;
    end
  end

  // ****************************************
  // array and prefetch path
  // ****************************************
  function automatic logic [D2CI_COL_W-1:0] col_at(input logic [D2CI_COL_W-1:0] base,
                                                   input logic [2:0] k,
                                                   input logic b8,
                                                   input logic il);
    logic [D2CI_COL_W-1:0] mask;
    logic [D2CI_COL_W-1:0] off;
    mask = b8 ? 8'h07 : 8'h03;
    off  = il ? ((base ^ {5'h00, k}) & mask) : ((base + {5'h00, k}) & mask);
    col_at = (base & ~mask) | off;
  endfunction

  logic [D2CI_DQ_W-1:0]       mem [2**MEM_AW];
  logic [D2CI_DQ_W-1:0]       pf_word [2];
  logic [2:0]                 k0;
  logic [MEM_AW-1:0]          idx [4];
  logic [D2CI_DQ_W-1:0]       merged [2];

  assign k0 = {eng_beat, 1'b0};

  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_idx
      assign idx[g] = {eng_ba, eng_row, col_at(eng_col, 3'(k0 + 3'(g)), burst8, interleave)};
    end
    for (g = 0; g < D2CI_LANES; g++) begin : g_lane
      assign merged[0][8*g +: 8] = (mask_en && wr_beat.mask_rise[g]) ? mem[idx[0]][8*g +: 8]
                                                                    : wr_beat.data_rise[8*g +: 8];
      assign merged[1][8*g +: 8] = (mask_en && wr_beat.mask_fall[g]) ? mem[idx[1]][8*g +: 8]
                                                                    : wr_beat.data_fall[8*g +: 8];
    end
  endgenerate

  // array holds no reset; contents are undefined until written
  always_ff @(posedge clk_sys) begin
    if (eng == ENG_XFER && eng_wr) begin
      mem[idx[0]] <= merged[0];
      mem[idx[1]] <= merged[1];
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      rd_beat    <= '0;
      rd_valid   <= 1'b0;
      dq_oe      <= 1'b0;
      pf_word[0] <= '0;
      pf_word[1] <= '0;
    end else begin
      rd_valid <= (eng == ENG_XFER) && !eng_wr;
      dq_oe    <= (eng == ENG_XFER) && !eng_wr;
      if (eng == ENG_XFER && !eng_wr) begin
        if (!eng_beat[0]) begin
          // four words per column access, upper pair parked
          rd_beat.rise <= mem[idx[0]];
          rd_beat.fall <= mem[idx[1]];
          pf_word[0]   <= mem[idx[2]];
          pf_word[1]   <= mem[idx[3]];
        end else begin
          rd_beat.rise <= pf_word[0];
          rd_beat.fall <= pf_word[1];
        end
      end
    end
  end

  // ****************************************
  // power states and termination
  // ****************************************
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      cke_q       <= 1'b0;
      power_state <= PWR_ON;
    end else begin
      cke_q <= cmd.cke;
      case (power_state)
        PWR_ON: begin
          // entry trusts the controller not to drop clock enable mid-burst
          if (cke_q && !cmd.cke) begin
            if (op == OP_REF && bank_open == '0) begin
              power_state <= PWR_SELF;
            end else if (|bank_open) begin
              power_state <= PWR_ACT_PD;
            end else begin
              power_state <= PWR_PRE_PD;
            end
          end
        end
        PWR_PRE_PD, PWR_ACT_PD: begin
          if (cmd.cke) begin
            power_state <= PWR_ON;
          end
        end
        PWR_SELF: begin
          // single-clock limitation: exit is seen at the first running edge
          if (cmd.cke) begin
            power_state <= PWR_ON;
          end
        end
        default: power_state <= PWR_ON;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      termination_on <= 1'b0;
    end else begin
      termination_on <= odt_en && termination_control && (power_state != PWR_SELF);
    end
  end

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);

  sequence s_rd_three;
    rd_go && (rl_total == 4'h3);
  endsequence

  sequence s_wr_three;
    wr_go && (rl_total == 4'h3);
  endsequence

  a_cs_masks: assert property ((cmd.cs_n && eng == ENG_IDLE) |=> $stable(bank_open))
    else $error("deselected command changed bank state");

  a_rd_latency: assert property (s_rd_three |=> !rd_valid ##1 !rd_valid ##1 !rd_valid ##1 rd_valid)
    else $error("read data not at programmed latency");

  a_wr_latency: assert property (s_wr_three |=> (eng == ENG_WAIT) ##1 (eng == ENG_WAIT) ##1 (eng == ENG_XFER))
    else $error("write capture not one cycle before read timing");

  a_burst_four: assert property (($rose(rd_valid) && !burst8) |-> rd_valid ##1 rd_valid ##1 !rd_valid)
    else $error("four-word burst has wrong length");

  a_burst_eight: assert property (($rose(rd_valid) && burst8) |-> rd_valid[*4] ##1 !rd_valid)
    else $error("eight-word burst has wrong length");

  a_cl_legal: assert property (read_latency >= D2CI_CL_MIN && read_latency <= D2CI_CL_MAX)
    else $error("read latency outside legal set");

  a_al_legal: assert property (posted_latency <= D2CI_AL_MAX)
    else $error("posted latency above limit");

  a_pd_select: assert property ((power_state == PWR_ON && cke_q && !cmd.cke && |bank_open)
                                |=> power_state == PWR_ACT_PD)
    else $error("open bank did not give active power-down");

  a_self_term: assert property (power_state == PWR_SELF |=> !termination_on)
    else $error("termination active in self refresh");

  a_pre_all: assert property ((rx_on && op == OP_PRE && cmd.addr[D2CI_AP_BIT]) |=> bank_open == '0)
    else $error("precharge all left a bank open");

  a_ap_close: assert property ((last_beat && eng_ap) |=> !bank_open[$past(eng_ba)])
    else $error("auto precharge did not close bank");

endmodule

// ### logic/d2ci_pkg.sv
package d2ci_pkg;

  // ****************************************
  // widths and geometry
  // ****************************************
  localparam int D2CI_ROW_W    = 13;
  localparam int D2CI_COL_W    = 8;
  localparam int D2CI_BA_W     = 2;
  localparam int D2CI_NBANK    = 4;
  localparam int D2CI_DQ_W     = 32;
  localparam int D2CI_LANES    = 4;
  localparam int D2CI_ROW_KEEP = 2;

  // ****************************************
  // address field positions
  // ****************************************
  localparam int D2CI_AP_BIT      = 10;
  localparam int D2CI_MR_BL_LSB   = 0;
  localparam int D2CI_MR_BT_BIT   = 3;
  localparam int D2CI_MR_CL_LSB   = 4;
  localparam int D2CI_MR_DRST_BIT = 8;
  localparam int D2CI_E1_DDIS_BIT = 0;
  localparam int D2CI_E1_DRV_BIT  = 1;
  localparam int D2CI_E1_ODT0_BIT = 2;
  localparam int D2CI_E1_AL_LSB   = 3;
  localparam int D2CI_E1_ODT1_BIT = 6;
  localparam int D2CI_E1_MSK_BIT  = 11;

  // ****************************************
  // codes, limits and reset values
  // ****************************************
  localparam logic [2:0] D2CI_BL4_CODE = 3'h2;
  localparam logic [2:0] D2CI_BL8_CODE = 3'h3;
  localparam logic [2:0] D2CI_CL_MIN   = 3'h3;
  localparam logic [2:0] D2CI_CL_MAX   = 3'h6;
  localparam logic [2:0] D2CI_AL_MAX   = 3'h5;
  localparam logic [2:0] D2CI_RST_CL   = 3'h3;
  localparam logic [2:0] D2CI_RST_AL   = 3'h0;
  localparam int         D2CI_DLL_LOCK_CYC = 200;

  // ****************************************
  // types
  // ****************************************
  typedef struct packed {
    logic                  cke;
    logic                  cs_n;
    logic                  ras_n;
    logic                  cas_n;
    logic                  we_n;
    logic [D2CI_BA_W-1:0]  ba;
    logic [D2CI_ROW_W-1:0] addr;
  } d2ci_cmd_t;

  typedef struct packed {
    logic [D2CI_DQ_W-1:0]  data_rise;
    logic [D2CI_DQ_W-1:0]  data_fall;
    logic [D2CI_LANES-1:0] mask_rise;
    logic [D2CI_LANES-1:0] mask_fall;
  } d2ci_wbeat_t;

  typedef struct packed {
    logic [D2CI_DQ_W-1:0] rise;
    logic [D2CI_DQ_W-1:0] fall;
  } d2ci_rbeat_t;

  typedef enum logic [3:0] {OP_DESEL, OP_NOP, OP_ACT, OP_READ, OP_WRITE, OP_PRE, OP_REF, OP_MRS} d2ci_op_t;
  typedef enum logic [1:0] {PWR_ON, PWR_PRE_PD, PWR_ACT_PD, PWR_SELF} d2ci_pwr_t;
  typedef enum logic [1:0] {ENG_IDLE, ENG_WAIT, ENG_XFER} d2ci_eng_t;

endpackage
